// File: design/acs_top.sv
// Top of the conversion sequencer: registers, sequencing and conflict handling.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Writing run bit 7 to one starts converting the selected input.
// - Each finished conversion loads both result registers and pulses the done request.
// - A finished conversion is followed at once by the next while running.
// - Mode or select writes abort and restart the conversion from its start.
// - Clearing the run bit stops at once; the result keeps the last finished conversion.
// - After a channel change the next done comes one conversion time later.
// - A result read coinciding with an update is served before the update.
// - A mode or select write beats an update; no load and no done request.
// - Standby halts conversion.
// - Select values zero to three pick analog inputs zero to three.
// - Result resolved MSB first from bit 9 down to bit 0.
// - Word result: top two bits in the high byte, low eight in low byte.
// - The result byte register holds the top eight result bits.
module acs_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [7:0]       rdata,
	input  wire logic        standby,
	input  wire logic        comp_out,
	output logic [1:0]       channel_sel,
	output logic             sample_hold,
	output logic [9:0]       dac_code,
	output logic             comparator_power,
	output logic             conversion_done_irq
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	acs_pkg::acs_bus_type  bus;
	acs_pkg::acs_state_type state;
	acs_pkg::acs_state_type next_state;
	logic [7:0] converter_mode_reg;
	logic [7:0] next_mode;
	logic [7:0] input_select_reg;
	logic [7:0] next_select;
	logic [9:0] result_word;
	logic [9:0] next_result;
	logic       irq_flag;
	logic       next_irq_flag;
	logic       next_irq_pulse;
	logic [7:0] next_rdata;
	logic [2:0] comp_sync;
	logic       comp_stable;
	logic       next_comp_stable;
	logic       ctrl_write;
	logic       restart;
	logic       tick;
	logic       sar_clear;
	logic       sar_step;
	logic       sar_last;
	logic [9:0] trial;
	logic       wr_mode;
	logic       wr_select;
	logic       wr_status;
	logic       rd_low;
	logic       rd_high;
	logic       rd_byte;
	logic       rd_mode;
	logic       rd_select;
	logic       rd_status;
	logic [1:0] next_channel_sel;
	logic       next_sample_hold;
	logic [9:0] next_dac_code;
	logic       next_comparator_power;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// Splits the ten-bit result into its register bytes.
	function automatic logic [7:0] result_byte(input logic [9:0] r, input logic [1:0] which);
		logic [7:0] b;
		b = acs_pkg::RESET_BYTE;
		if (which == 2'b00) begin
			b = r[acs_pkg::LOW_BYTE_BITS-1:0];
		end else if (which == 2'b01) begin
			b = {6'h00, r[acs_pkg::RESULT_BITS-1:acs_pkg::LOW_BYTE_BITS]};
		end else begin
			b = r[acs_pkg::RESULT_BITS-1:acs_pkg::RESULT_BITS-8];
		end
		return b;
	endfunction

	// Decodes one strobe at one address.
	function automatic logic strobe_at(input logic strobe, input logic [15:0] a,
			input logic [15:0] want);
		return strobe && a == want;
	endfunction

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Every access is decoded once, so the sequencer and the register file
	// can never disagree about which register a strobe meant.
	assign wr_mode   = strobe_at(bus.wr, bus.addr, acs_pkg::ADDR_MODE);
	assign wr_select = strobe_at(bus.wr, bus.addr, acs_pkg::ADDR_SELECT);
	assign wr_status = strobe_at(bus.wr, bus.addr, acs_pkg::ADDR_STATUS);
	assign rd_low    = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_RESULT_LOW);
	assign rd_high   = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_RESULT_HIGH);
	assign rd_byte   = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_RESULT_BYTE);
	assign rd_mode   = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_MODE);
	assign rd_select = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_SELECT);
	assign rd_status = strobe_at(bus.rd, bus.addr, acs_pkg::ADDR_STATUS);

	// ----------------------------------------------------------------
	// Leaf blocks
	// ----------------------------------------------------------------
	acs_timer u_timer (
		.clk       (clk),
		.rst       (rst),
		.restart   (restart),
		.time_code (converter_mode_reg[acs_pkg::TIME_MSB:acs_pkg::TIME_LSB]),
		.tick      (tick)
	);

	acs_sar u_sar (
		.clk       (clk),
		.rst       (rst),
		.clear     (sar_clear),
		.step      (sar_step),
		.comp_high (comp_stable),
		.trial     (trial),
		.last      (sar_last)
	);

	// ----------------------------------------------------------------
	// Comparator input filter
	// ----------------------------------------------------------------
	// The analog verdict arrives unsynchronised; it counts only when two late stages agree.
	always_comb begin
		next_comp_stable = comp_stable;
		if (comp_sync[2] == comp_sync[1]) begin
			next_comp_stable = comp_sync[1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			comp_sync   <= 3'b000;
			comp_stable <= 1'b0;
		end else begin
			comp_sync   <= {comp_sync[1:0], comp_out};
			comp_stable <= next_comp_stable;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// A control write always restarts the timer, so the first done after a
	// channel change lies exactly one conversion time away.
	assign ctrl_write = wr_mode || wr_select;
	assign restart    = ctrl_write || state == acs_pkg::ACS_IDLE;

	always_comb begin
		next_state = state;
		sar_clear = 1'b0;
		sar_step = 1'b0;
		next_irq_pulse = 1'b0;
		next_result = result_word;
		if (!next_mode[acs_pkg::RUN_BIT] || standby) begin
			next_state = acs_pkg::ACS_IDLE;
		end else if (ctrl_write) begin
			next_state = acs_pkg::ACS_SAMPLE;
			sar_clear = 1'b1;
		end else begin
			case (state)
				acs_pkg::ACS_IDLE: begin
					next_state = acs_pkg::ACS_SAMPLE;
					sar_clear = 1'b1;
				end
				acs_pkg::ACS_SAMPLE: begin
					if (tick) begin
						next_state = acs_pkg::ACS_STEP;
					end
				end
				acs_pkg::ACS_STEP: begin
					if (tick) begin
						sar_step = 1'b1;
						if (sar_last) begin
							// Final bit resolved here; the completed code goes straight to the result.
							next_result = (trial & ~(comp_stable ? 10'h000 : 10'h001));
							next_irq_pulse = 1'b1;
							next_state = acs_pkg::ACS_SAMPLE;
							// Rearm the approximation, or the next conversion never finds its last bit.
							sar_clear = 1'b1;
						end
					end
				end
				default: begin
					next_state = acs_pkg::ACS_IDLE;
				end
			endcase
		end
	end

	// Sequencing registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= acs_pkg::ACS_IDLE;
			result_word <= 10'h000;
			conversion_done_irq <= 1'b0;
		end else begin
			state <= next_state;
			result_word <= next_result;
			conversion_done_irq <= next_irq_pulse;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// The read takes the old result; a coinciding update lands on the same edge as the read data.
	// Set beats clear on the done flag, so a finish in the clearing cycle is never lost.
	always_comb begin
		next_mode = converter_mode_reg;
		next_select = input_select_reg;
		next_irq_flag = irq_flag;
		next_rdata = acs_pkg::RESET_BYTE;
		if (wr_mode) begin
			next_mode = bus.wdata & acs_pkg::MODE_WRITE_MASK;
		end else if (wr_select) begin
			next_select = bus.wdata & acs_pkg::SELECT_WRITE_MASK;
		end else if (wr_status) begin
			if (bus.wdata[acs_pkg::STATUS_IRQ_BIT]) begin
				next_irq_flag = 1'b0;
			end
		end
		if (next_irq_pulse) begin
			next_irq_flag = 1'b1;
		end
		if (rd_low) begin
			next_rdata = result_byte(result_word, 2'b00);
		end else if (rd_high) begin
			next_rdata = result_byte(result_word, 2'b01);
		end else if (rd_byte) begin
			next_rdata = result_byte(result_word, 2'b10);
		end else if (rd_mode) begin
			next_rdata = converter_mode_reg;
		end else if (rd_select) begin
			next_rdata = input_select_reg;
		end else if (rd_status) begin
			next_rdata[acs_pkg::STATUS_BUSY_BIT] = state != acs_pkg::ACS_IDLE;
			next_rdata[acs_pkg::STATUS_IRQ_BIT] = irq_flag;
		end
	end

	// Register file storage.
	always_ff @(posedge clk) begin
		if (rst) begin
			converter_mode_reg <= acs_pkg::RESET_BYTE;
			input_select_reg <= acs_pkg::RESET_BYTE;
			irq_flag <= 1'b0;
			rdata <= acs_pkg::RESET_BYTE;
		end else begin
			converter_mode_reg <= next_mode;
			input_select_reg <= next_select;
			irq_flag <= next_irq_flag;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin drives
	// ----------------------------------------------------------------
	// The pins take the next values, so the channel switch and the hold command
	// change on the same edge as the sequencer state.
	// The trial code still reaches the comparator a few cycles late; the step
	// timer hides that only for conversion-time codes above zero.
	always_comb begin
		next_channel_sel = next_select[1:0];
		next_sample_hold = next_state == acs_pkg::ACS_SAMPLE;
		next_dac_code = trial;
		next_comparator_power = next_mode[acs_pkg::POWER_BIT];
	end

	// Pin registers; every output leaves the block straight from a flop.
	always_ff @(posedge clk) begin
		if (rst) begin
			channel_sel <= 2'b00;
			sample_hold <= 1'b0;
			dac_code <= 10'h000;
			comparator_power <= 1'b0;
		end else begin
			channel_sel <= next_channel_sel;
			sample_hold <= next_sample_hold;
			dac_code <= next_dac_code;
			comparator_power <= next_comparator_power;
		end
	end
endmodule
`default_nettype wire

// File: design/acs_pkg.sv
// Package of register map, field layout and timing constants for the conversion sequencer.
package acs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_RESULT_LOW  = 16'hFF18;
	localparam logic [15:0] ADDR_RESULT_HIGH = 16'hFF19;
	localparam logic [15:0] ADDR_RESULT_BYTE = 16'hFF1A;
	localparam logic [15:0] ADDR_MODE        = 16'hFF80;
	localparam logic [15:0] ADDR_SELECT      = 16'hFF81;
	localparam logic [15:0] ADDR_STATUS      = 16'hFF82;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int RUN_BIT        = 7;
	localparam int POWER_BIT      = 0;
	localparam int TIME_LSB       = 3;
	localparam int TIME_MSB       = 5;
	localparam int RESULT_BITS    = 10;
	localparam int LOW_BYTE_BITS  = 8;
	localparam int STATUS_IRQ_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;
	localparam logic [7:0] MODE_WRITE_MASK   = 8'hB9;
	localparam logic [7:0] SELECT_WRITE_MASK = 8'h03;
	localparam logic [7:0] RESET_BYTE        = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam logic [15:0] CYCLES_PER_STEP_BASE = 16'h0004;

	// Sequencer states.
	typedef enum logic [1:0] {
		ACS_IDLE   = 2'b00,
		ACS_SAMPLE = 2'b01,
		ACS_STEP   = 2'b10
	} acs_state_type;

	// One register bus request.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} acs_bus_type;

endpackage

// File: design/acs_timer.sv
// Step timer that spaces the conversion steps by the programmed conversion time.
`timescale 1ns/1ps
`default_nettype none
module acs_timer (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        restart,
	input  wire logic [2:0]  time_code,
	output logic             tick
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] limit;

	// Each code doubles the base step length; longer codes give slower steps.
	always_comb begin
		limit = 16'(acs_pkg::CYCLES_PER_STEP_BASE << time_code) - 16'h0001;
		next_count = count + 16'h0001;
		tick = 1'b0;
		if (restart) begin
			next_count = 16'h0000;
		end else if (count >= limit) begin
			next_count = 16'h0000;
			tick = 1'b1;
		end
	end

	// Register the counter.
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 16'h0000;
		end else begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// File: design/acs_sar.sv
// Successive approximation register resolving ten bits from the most significant down.
`timescale 1ns/1ps
`default_nettype none
module acs_sar (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        step,
	input  wire logic        comp_high,
	output logic [9:0]       trial,
	output logic             last
);
	logic [9:0] bitpos;
	logic [9:0] next_trial;
	logic [9:0] next_bitpos;

	// On a step the tested bit keeps the comparator verdict and the next bit is tried.
	always_comb begin
		next_trial  = trial;
		next_bitpos = bitpos;
		last = bitpos[0];
		if (clear) begin
			next_trial  = 10'h200;
			next_bitpos = 10'h200;
		end else if (step) begin
			next_trial  = (trial & ~(comp_high ? 10'h000 : bitpos)) | (bitpos >> 1);
			next_bitpos = bitpos >> 1;
		end
	end

	// Register the approximation.
	always_ff @(posedge clk) begin
		if (rst) begin
			trial  <= 10'h000;
			bitpos <= 10'h000;
		end else begin
			trial  <= next_trial;
			bitpos <= next_bitpos;
		end
	end
endmodule
`default_nettype wire

// File: tb/acs_analog_model.sv
// Behavioural analog side: four input levels, a hold capacitor and a comparator.
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [39:0] levels,
	input  wire logic [1:0]  channel_sel,
	input  wire logic        sample_hold,
	input  wire logic [9:0]  dac_code,
	input  wire logic        comparator_power,
	output logic             comp_out
);
	logic [9:0] held;

	// The level is held outside sampling, so a late channel change cannot leak in.
	always_ff @(posedge clk) begin
		if (rst) begin
			held <= 10'h000;
		end else if (sample_hold) begin
			held <= levels[10 * int'(channel_sel) +: 10];
		end
	end

	// An unpowered comparator reads low, as the real one gives no useful verdict.
	assign comp_out = comparator_power && (held >= dac_code);
endmodule
`default_nettype wire

// File: tb/acs_props.sv
// Concurrent checks on the ports of the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module acs_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        standby,
	input wire logic        comp_out,
	input wire logic [1:0]  channel_sel,
	input wire logic        sample_hold,
	input wire logic [9:0]  dac_code,
	input wire logic        comparator_power,
	input wire logic        conversion_done_irq
);
	logic mode_wr;
	logic sel_wr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Control writes; both of them restart the sequence.
	assign mode_wr = wr && addr == acs_pkg::ADDR_MODE;
	assign sel_wr  = wr && addr == acs_pkg::ADDR_SELECT;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	run_start_a: assert property (mode_wr && wdata[7] && !standby |-> ##[1:2] sample_hold)
		else $error("run write did not start sampling");
	next_start_a: assert property (conversion_done_irq && !standby |-> ##[0:1] sample_hold)
		else $error("no new conversion after a finished one");
	write_wins_a: assert property (mode_wr || sel_wr |=> !conversion_done_irq)
		else $error("done request beside a control write");
	stop_quiet_a: assert property (mode_wr && !wdata[7] |=>
		!(sample_hold || conversion_done_irq) [*8])
		else $error("activity after run was cleared");
	standby_halt_a: assert property (standby ##1 standby |->
		!sample_hold && !conversion_done_irq)
		else $error("conversion active in standby");
	msb_first_a: assert property ($fell(sample_hold) && !$past(wr) && !$past(standby)
		|-> ##[0:1] dac_code == 10'h200)
		else $error("first trial is not the top bit");
	chan_read_a: assert property (rd && addr == acs_pkg::ADDR_SELECT |=>
		rdata == {6'h00, channel_sel})
		else $error("select read differs from channel output");
	irq_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("done request longer than one cycle");
	power_pin_a: assert property (mode_wr |=> comparator_power == $past(wdata[0]))
		else $error("comparator power pin differs from the written bit");

	cover property (conversion_done_irq);
	cover property (sel_wr ##[1:200] conversion_done_irq);
	cover property (standby ##1 standby);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the conversion sequencer with its analog side model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Levels stay fixed, so nothing disturbs the shared pins while they convert.
	localparam logic [39:0] LEVELS = 40'h00_3ff4_f2a5;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        standby = 1'b0;
	logic [7:0]  rdata;
	logic        comp_out, sample_hold, comparator_power, conversion_done_irq;
	logic [1:0]  channel_sel;
	logic [9:0]  dac_code, v;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n, t;

	always #50 clk = ~clk;

	acs_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .standby(standby), .comp_out(comp_out), .channel_sel(channel_sel),
		.sample_hold(sample_hold), .dac_code(dac_code), .comparator_power(comparator_power),
		.conversion_done_irq(conversion_done_irq));
	acs_analog_model model (.clk(clk), .rst(rst), .levels(LEVELS), .channel_sel(channel_sel),
		.sample_hold(sample_hold), .dac_code(dac_code), .comparator_power(comparator_power),
		.comp_out(comp_out));

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic final_report;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
		@(posedge clk);
		addr  <= a;
		wdata <= x;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so it is taken just past that edge.
	task automatic expect_rd(input string what, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(what, {8'h00, rdata}, {8'h00, exp});
	endtask
	// Bounded wait; cnt is the number of edges until the done pulse, or limit.
	task automatic wait_irq(input int limit, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1 cnt++;
		end while (conversion_done_irq !== 1'b1 && cnt < limit);
	endtask

	// A hung handshake is cut short here and counted as a mismatch.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		expect_rd("mode reset", acs_pkg::ADDR_MODE, 8'h00);
		expect_rd("unmapped", 16'hff83, 8'h00);
		wr_reg(acs_pkg::ADDR_MODE, 8'hfe);
		expect_rd("mode mask", acs_pkg::ADDR_MODE, 8'hb8);
		wr_reg(acs_pkg::ADDR_SELECT, 8'hff);
		expect_rd("select mask", acs_pkg::ADDR_SELECT, 8'h03);
		wr_reg(acs_pkg::ADDR_MODE, 8'h01);
		repeat (10) @(posedge clk);
		for (int ch = 0; ch < 4; ch++) begin
			t = 11 * (4 << (ch / 2 + 1));
			wr_reg(acs_pkg::ADDR_MODE, 8'h81 | 8'((ch / 2 + 1) << 3));
			wr_reg(acs_pkg::ADDR_SELECT, 8'(ch));
			wait_irq(2 * t, n);
			check("time after select", 16'(n >= t - 1 && n <= t + 2), 16'h0001);
			wait_irq(2 * t, n);
			check("back to back", 16'(n >= t - 1 && n <= t + 2), 16'h0001);
			v = LEVELS[10 * ch +: 10];
			expect_rd("result low", acs_pkg::ADDR_RESULT_LOW, v[7:0]);
			expect_rd("result high", acs_pkg::ADDR_RESULT_HIGH, {6'h00, v[9:8]});
			expect_rd("result top", acs_pkg::ADDR_RESULT_BYTE, v[9:2]);
		end
		expect_rd("status set", acs_pkg::ADDR_STATUS, 8'h03);
		wr_reg(acs_pkg::ADDR_STATUS, 8'h01);
		expect_rd("status cleared", acs_pkg::ADDR_STATUS, 8'h02);
		wr_reg(acs_pkg::ADDR_MODE, 8'h89);
		wr_reg(acs_pkg::ADDR_SELECT, 8'h01);
		wait_irq(400, n);
		wr_reg(acs_pkg::ADDR_SELECT, 8'h00);
		repeat (n - 2) @(posedge clk);
		expect_rd("read before load", acs_pkg::ADDR_RESULT_LOW, 8'h3c);
		expect_rd("load after read", acs_pkg::ADDR_RESULT_LOW, 8'ha5);
		wr_reg(acs_pkg::ADDR_SELECT, 8'h02);
		repeat (n - 2) @(posedge clk);
		wr_reg(acs_pkg::ADDR_SELECT, 8'h02);
		#1 check("irq beside write", 16'(conversion_done_irq), 16'h0000);
		expect_rd("no load", acs_pkg::ADDR_RESULT_LOW, 8'ha5);
		wait_irq(2 * n, t);
		expect_rd("restarted result", acs_pkg::ADDR_RESULT_LOW, 8'hff);
		wr_reg(acs_pkg::ADDR_MODE, 8'h09);
		wait_irq(2 * n, t);
		check("stopped", 16'(t), 16'(2 * n));
		wr_reg(acs_pkg::ADDR_MODE, 8'h89);
		@(posedge clk);
		standby <= 1'b1;
		wait_irq(2 * n, t);
		check("standby", 16'(t), 16'(2 * n));
		@(posedge clk);
		standby <= 1'b0;
		final_report();
	end
endmodule

bind acs_top acs_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .standby(standby), .comp_out(comp_out),
	.channel_sel(channel_sel), .sample_hold(sample_hold), .dac_code(dac_code),
	.comparator_power(comparator_power), .conversion_done_irq(conversion_done_irq));
`default_nettype wire
